// ### rtl/config_overlay_cmd_handler.sv
`timescale 1ns/1ns
`default_nettype none

module config_overlay_cmd_handler
    import dco_pkg::*;
(
    input  wire logic        clock_i,       // System clock, 50 MHz
    input  wire logic        rst_i,         // Hardware or software reset
    input  wire logic        power_down_i,  // Power-on / power-down reset
    input  wire logic        cmd_valid_i,   // Task-file command written
    input  wire cmd_t        cmd_i,         // Command and feature bytes
    input  wire cap_words_t  full_cap_i,    // Full selectable capabilities
    input  wire logic [63:0] native_lba_i,  // Native maximum LBA
    input  wire logic        hpa_set_i,     // Protected area established
    input  wire logic        sec_enabled_i, // Security feature enabled
    input  wire logic        sec_locked_i,  // Security locked
    input  wire logic        din_ready_i,   // Host takes a data-in word
    output logic             din_valid_o,   // Data-in word offered
    output logic [15:0]      din_word_o,    // Data-in word
    input  wire logic        dout_valid_i,  // Host offers a data-out word
    input  wire logic [15:0] dout_word_i,   // Data-out word
    output logic             dout_ready_o,  // Data-out word taken
    output logic             busy_o,        // Command in progress
    output logic             done_o,        // Command complete, one cycle
    output tf_result_t       result_o,      // Abort flag and error fields
    output cap_words_t       eff_cap_o,     // Capabilities after overlay
    output logic [63:0]      eff_lba_o,     // Maximum LBA after overlay
    output logic             frozen_o,      // Overlay frozen
    output logic             modified_o     // Overlay has been set
);

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DECIDE,
        ST_RD,
        ST_LAT,
        ST_SEND,
        ST_RECV,
        ST_CHECK
    } state_t;

    state_t      state_q;
    state_t      state_d;
    logic [7:0]  sub_q;
    logic [7:0]  idx_q;
    logic [7:0]  sum_q;
    logic [15:0] rdata;
    logic        rd_en;
    logic        reset_any;
    logic        frozen_q;
    logic        modified_q;
    cap_words_t  allow_q;
    logic [63:0] lba_q;
    logic        lba_set_q;
    cap_words_t  rx_q;
    logic [63:0] rx_lba_q;
    logic        fin;
    tf_result_t  fin_res;
    logic        do_restore;
    logic        do_freeze;
    logic        do_set;
    logic [15:0] din_q;
    logic        done_q;
    tf_result_t  res_q;

    // Freeze and overlay state must outlive ordinary resets
    assign reset_any = rst_i | power_down_i;

    ////////////////////////////////////////////////////////////////////
    // Structure word source

    assign rd_en = (state_q == ST_RD);

    dco_struct_rom u_rom (
        .clock_i      (clock_i),
        .rd_en_i      (rd_en),
        .addr_i       (idx_q),
        .full_cap_i   (full_cap_i),
        .native_lba_i (native_lba_i),
        .rdata_o      (rdata)
    );

    ////////////////////////////////////////////////////////////////////
    // Sequencing

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_IDLE:
            begin
                if (cmd_valid_i && cmd_i.command == CMD_OVERLAY)
                begin
                    state_d = ST_DECIDE;
                end
            end
            ST_DECIDE:
            begin
                if (fin)
                begin
                    state_d = ST_IDLE;
                end
                else if (sub_q == SUB_IDENTIFY)
                begin
                    state_d = ST_RD;
                end
                else
                begin
                    state_d = ST_RECV;
                end
            end
            ST_RD:
            begin
                state_d = ST_LAT;
            end
            ST_LAT:
            begin
                state_d = ST_SEND;
            end
            ST_SEND:
            begin
                if (din_ready_i)
                begin
                    state_d = (idx_q == W_LAST) ? ST_IDLE : ST_RD;
                end
            end
            ST_RECV:
            begin
                if (dout_valid_i && idx_q == W_LAST)
                begin
                    state_d = ST_CHECK;
                end
            end
            ST_CHECK:
            begin
                state_d = ST_IDLE;
            end
            default:
            begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_i)
    begin
        if (reset_any)
        begin
            state_q <= ST_IDLE;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (state_q == ST_IDLE && cmd_valid_i)
        begin
            sub_q <= cmd_i.feature;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outcome of each subcommand

    always_comb
    begin
        fin        = 1'b0;
        fin_res    = '0;
        do_restore = 1'b0;
        do_freeze  = 1'b0;
        do_set     = 1'b0;
        case (state_q)
            ST_DECIDE:
            begin
                if (sub_q != SUB_RESTORE && sub_q != SUB_FREEZE &&
                    sub_q != SUB_IDENTIFY && sub_q != SUB_SET)
                begin
                    fin            = 1'b1;
                    fin_res.abort  = 1'b1;
                    fin_res.reason = RSN_BAD_SUB;
                end
                else if (frozen_q)
                begin
                    fin            = 1'b1;
                    fin_res.abort  = 1'b1;
                    fin_res.reason = RSN_FROZEN;
                end
                else if (sub_q == SUB_FREEZE)
                begin
                    fin       = 1'b1;
                    do_freeze = 1'b1;
                end
                else if (sub_q != SUB_IDENTIFY && sec_locked_i)
                begin
                    fin            = 1'b1;
                    fin_res.abort  = 1'b1;
                    fin_res.reason = RSN_SEC_LOCKED;
                end
                else if (sub_q == SUB_RESTORE)
                begin
                    fin = 1'b1;
                    if (hpa_set_i && eff_lba_o != native_lba_i)
                    begin
                        fin_res.abort  = 1'b1;
                        fin_res.reason = RSN_PROTECTED;
                        fin_res.word   = W_LBA0;
                    end
                    else
                    begin
                        do_restore = 1'b1;
                    end
                end
                else if (sub_q == SUB_SET && modified_q)
                begin
                    fin            = 1'b1;
                    fin_res.abort  = 1'b1;
                    fin_res.reason = RSN_MODIFIED;
                end
            end
            ST_SEND:
            begin
                fin = din_ready_i && idx_q == W_LAST;
            end
            ST_CHECK:
            begin
                fin = 1'b1;
                if (hpa_set_i && rx_lba_q != eff_lba_o)
                begin
                    fin_res.abort  = 1'b1;
                    fin_res.reason = RSN_PROTECTED;
                    fin_res.word   = W_LBA0;
                end
                else if (sec_enabled_i && eff_cap_o.feat[SEC_BIT] &&
                         !rx_q.feat[SEC_BIT])
                begin
                    fin             = 1'b1;
                    fin_res.abort   = 1'b1;
                    fin_res.reason  = RSN_DISABLE;
                    fin_res.word    = W_FEAT;
                    fin_res.mask_hi = 8'h00;
                    fin_res.mask_lo = SEC_MASK;
                end
                else
                begin
                    do_set = 1'b1;
                end
            end
            default:
            begin
                fin = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Overlay state, cleared at power-down; allow and LBA state also cleared by restore

    always_ff @(posedge clock_i)
    begin
        if (power_down_i)
        begin
            frozen_q <= 1'b0;
        end
        else if (do_freeze)
        begin
            frozen_q <= 1'b1;
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (power_down_i || do_restore)
        begin
            allow_q    <= {5{ALL_ALLOWED}};
            lba_q      <= '0;
            lba_set_q  <= 1'b0;
            modified_q <= 1'b0;
        end
        else if (do_set)
        begin
            // Bits the host sets beyond the full set have no effect
            allow_q    <= rx_q;
            lba_q      <= (rx_lba_q < native_lba_i) ? rx_lba_q : native_lba_i;
            lba_set_q  <= 1'b1;
            modified_q <= 1'b1;
        end
    end

    // Reduced set seen by identify-device; overlay identify stays full
    assign eff_cap_o       = full_cap_i & allow_q;
    assign eff_lba_o       = lba_set_q ? lba_q : native_lba_i;
    assign frozen_o        = frozen_q;
    assign modified_o      = modified_q;

    ////////////////////////////////////////////////////////////////////
    // Word counter, data-out capture and data-in checksum

    always_ff @(posedge clock_i)
    begin
        if (state_q == ST_DECIDE)
        begin
            idx_q <= 8'h00;
        end
        else if ((state_q == ST_SEND && din_ready_i) ||
                 (state_q == ST_RECV && dout_valid_i))
        begin
            idx_q <= idx_q + 8'h01;
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (state_q == ST_DECIDE)
        begin
            sum_q <= 8'h00;
        end
        else if (state_q == ST_SEND && din_ready_i)
        begin
            sum_q <= sum_q + din_q[15:8] + din_q[7:0];
        end
    end

    // Last word gets its checksum patched in on the way out
    always_ff @(posedge clock_i)
    begin
        if (reset_any)
        begin
            din_q <= 16'h0000;
        end
        else if (state_q == ST_LAT)
        begin
            if (idx_q == W_LAST)
            begin
                din_q <= {8'h00 - sum_q - SIGNATURE, SIGNATURE};
            end
            else
            begin
                din_q <= rdata;
            end
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (state_q == ST_DECIDE)
        begin
            rx_q     <= '0;
            rx_lba_q <= '0;
        end
        else if (state_q == ST_RECV && dout_valid_i)
        begin
            case (idx_q)
                W_MWDMA: rx_q.mwdma <= dout_word_i;
                W_UDMA:  rx_q.udma  <= dout_word_i;
                W_LBA0:  rx_lba_q[15:0]  <= dout_word_i;
                W_LBA1:  rx_lba_q[31:16] <= dout_word_i;
                W_LBA2:  rx_lba_q[47:32] <= dout_word_i;
                W_LBA3:  rx_lba_q[63:48] <= dout_word_i;
                W_FEAT:  rx_q.feat  <= dout_word_i;
                W_SATA:  rx_q.sata  <= dout_word_i;
                W_WUNC:  rx_q.wunc  <= dout_word_i;
                default: rx_q.wunc  <= rx_q.wunc;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Completion report

    always_ff @(posedge clock_i)
    begin
        if (reset_any)
        begin
            done_q <= 1'b0;
            res_q  <= '0;
        end
        else
        begin
            done_q <= fin;
            if (fin)
            begin
                res_q <= fin_res;
            end
        end
    end

    assign din_valid_o  = (state_q == ST_SEND);
    assign din_word_o   = din_q;
    assign dout_ready_o = (state_q == ST_RECV);
    assign busy_o       = (state_q != ST_IDLE);
    assign done_o       = done_q;
    assign result_o     = res_q;

endmodule

`default_nettype wire

// ### rtl/dco_pkg.sv
package dco_pkg;

    // Command and subcommand codes
    localparam logic [7:0] CMD_OVERLAY  = 8'hB1;
    localparam logic [7:0] SUB_RESTORE  = 8'hC0;
    localparam logic [7:0] SUB_FREEZE   = 8'hC1;
    localparam logic [7:0] SUB_IDENTIFY = 8'hC2;
    localparam logic [7:0] SUB_SET      = 8'hC3;

    // Abort reason codes, reported in the sector count field
    localparam logic [7:0] RSN_NONE        = 8'h00;
    localparam logic [7:0] RSN_FROZEN      = 8'h01;
    localparam logic [7:0] RSN_SEC_LOCKED  = 8'h02;
    localparam logic [7:0] RSN_MODIFIED    = 8'h03;
    localparam logic [7:0] RSN_DISABLE     = 8'h04;
    localparam logic [7:0] RSN_MAXADDR     = 8'h05;
    localparam logic [7:0] RSN_PROTECTED   = 8'h06;
    localparam logic [7:0] RSN_UNSUPPORTED = 8'h07;
    localparam logic [7:0] RSN_BAD_SUB     = 8'h08;
    localparam logic [7:0] RSN_OTHER       = 8'hFF;

    // Word indices of the overlay structure
    localparam int          STRUCT_WORDS = 256;
    localparam logic [7:0] W_REV   = 8'h00;
    localparam logic [7:0] W_MWDMA = 8'h01;
    localparam logic [7:0] W_UDMA  = 8'h02;
    localparam logic [7:0] W_LBA0  = 8'h03;
    localparam logic [7:0] W_LBA1  = 8'h04;
    localparam logic [7:0] W_LBA2  = 8'h05;
    localparam logic [7:0] W_LBA3  = 8'h06;
    localparam logic [7:0] W_FEAT  = 8'h07;
    localparam logic [7:0] W_SATA  = 8'h08;
    localparam logic [7:0] W_WUNC  = 8'h15;
    localparam logic [7:0] W_LAST  = 8'hFF;

    // Fixed contents and defined-bit masks
    localparam logic [15:0] REV_VALUE  = 16'h0002;
    localparam logic [7:0]  SIGNATURE  = 8'hA5;
    localparam logic [15:0] MASK_MWDMA = 16'h0007;
    localparam logic [15:0] MASK_UDMA  = 16'h007F;
    localparam logic [15:0] MASK_FEAT  = 16'h1BBF;
    localparam logic [15:0] MASK_SATA  = 16'h0017;
    localparam logic [15:0] MASK_WUNC  = 16'h2000;
    localparam int          SEC_BIT    = 3;
    localparam logic [7:0]  SEC_MASK   = 8'h08;
    localparam logic [15:0] ALL_ALLOWED = 16'hFFFF;

    typedef struct packed {
        logic [15:0] mwdma;
        logic [15:0] udma;
        logic [15:0] feat;
        logic [15:0] sata;
        logic [15:0] wunc;
    } cap_words_t;

    typedef struct packed {
        logic [7:0] command;
        logic [7:0] feature;
    } cmd_t;

    typedef struct packed {
        logic       abort;
        logic [7:0] reason;
        logic [7:0] word;
        logic [7:0] mask_hi;
        logic [7:0] mask_lo;
    } tf_result_t;

endpackage

// ### rtl/dco_struct_rom.sv
`timescale 1ns/1ns
`default_nettype none

module dco_struct_rom
    import dco_pkg::*;
(
    input  wire logic        clock_i,      // System clock
    input  wire logic        rd_en_i,      // Read strobe
    input  wire logic [7:0]  addr_i,       // Structure word index
    input  wire cap_words_t  full_cap_i,   // Full selectable capabilities
    input  wire logic [63:0] native_lba_i, // Native maximum LBA
    output logic [15:0]      rdata_o       // Word, one cycle after strobe
);

    logic [15:0] word;

    always_comb
    begin
        case (addr_i)
            W_REV:   word = REV_VALUE;
            W_MWDMA: word = full_cap_i.mwdma & MASK_MWDMA;
            W_UDMA:  word = full_cap_i.udma & MASK_UDMA;
            W_LBA0:  word = native_lba_i[15:0];
            W_LBA1:  word = native_lba_i[31:16];
            W_LBA2:  word = native_lba_i[47:32];
            W_LBA3:  word = native_lba_i[63:48];
            W_FEAT:  word = full_cap_i.feat & MASK_FEAT;
            W_SATA:  word = full_cap_i.sata & MASK_SATA;
            W_WUNC:  word = full_cap_i.wunc & MASK_WUNC;
            W_LAST:  word = {8'h00, SIGNATURE};
            default: word = 16'h0000;
        endcase
    end

    always_ff @(posedge clock_i)
    begin
        if (rd_en_i)
        begin
            rdata_o <= word;
        end
    end

endmodule

`default_nettype wire

// ### test/dco_host_model.sv
`timescale 1ns/1ns
`default_nettype none

module dco_host_model
(
    input  wire logic        clock_i,      // Clock
    input  wire logic        stall_i,      // Slow host
    input  wire logic        din_valid_i,  // Device offers word
    input  wire logic [15:0] din_word_i,   // Word from device
    output logic             din_ready_o,  // Host takes word
    output logic             dout_valid_o, // Host offers word
    output logic [15:0]      dout_word_o,  // Word to device
    input  wire logic        dout_ready_i  // Device takes word
);
    logic [15:0] rx_mem [256];
    logic [15:0] tx_mem [256];
    int          rx_n = 0;
    int          tx_n = 0;
    logic        ph = 1'b0;

    initial
    begin
        din_ready_o = 1'b0;
        dout_valid_o = 1'b0;
        dout_word_o = 16'h0000;
    end

    ////////////////////////////////////////////////////////////////////////////////
    always @(negedge clock_i)
    begin
        ph <= ~ph;
        din_ready_o <= din_valid_i && !(stall_i && ph);
        // Ready is high all through receive, so an offered word is taken
        if (dout_ready_i && tx_n < 256 && !(stall_i && ph))
        begin
            dout_valid_o <= 1'b1;
            dout_word_o <= tx_mem[tx_n];
        end
        else
        begin
            dout_valid_o <= 1'b0;
            dout_word_o <= ~dout_word_o;
        end
    end

    always @(posedge clock_i)
    begin
        if (din_valid_i && din_ready_o)
        begin
            rx_mem[rx_n[7:0]] <= din_word_i;
            rx_n <= rx_n + 1;
        end
        if (dout_valid_o && dout_ready_i)
            tx_n <= tx_n + 1;
    end
endmodule

`default_nettype wire

// ### test/dco_handler_asserts.sv
`timescale 1ns/1ns
`default_nettype none

module dco_handler_asserts
    import dco_pkg::*;
(
    input  wire logic        clock_i,      // Clock
    input  wire logic        rst_i,        // Reset
    input  wire logic        power_down_i, // Power-down
    input  wire logic        cmd_valid_i,  // Command strobe
    input  wire cmd_t        cmd_i,        // Command bytes
    input  wire cap_words_t  full_cap_i,   // Full set
    input  wire logic        hpa_set_i,    // Protected area
    input  wire logic        sec_locked_i, // Locked
    input  wire logic        din_ready_i,  // Host ready
    input  wire logic        din_valid_o,  // Word offered
    input  wire logic [15:0] din_word_o,   // Word
    input  wire logic        busy_o,       // Busy
    input  wire logic        done_o,       // Done pulse
    input  wire tf_result_t  result_o,     // Result
    input  wire cap_words_t  eff_cap_o,    // Effective set
    input  wire logic        frozen_o,     // Frozen
    input  wire logic        modified_o    // Set applied
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i || power_down_i);

    logic take;
    logic known;
    // Conservative idle test: a take in the done cycle is not judged
    assign take  = cmd_valid_i && !busy_o && !done_o && cmd_i.command == CMD_OVERLAY;
    assign known = cmd_i.feature inside {SUB_RESTORE, SUB_FREEZE, SUB_IDENTIFY, SUB_SET};

    sequence s_abort(logic [7:0] r);
        done_o && result_o.abort && result_o.reason == r;
    endsequence
    sequence s_ok;
        done_o && !result_o.abort;
    endsequence

    ////////////////////////////////////////////////////////////////////////////////
    a_bad_sub: assert property (
        take && !known |-> ##2 s_abort(RSN_BAD_SUB))
        else $error("reserved subcommand not refused");
    a_frozen_abort: assert property (
        take && known && frozen_o |-> ##2 s_abort(RSN_FROZEN))
        else $error("frozen subcommand not refused");
    a_freeze_sets: assert property (
        take && !frozen_o && cmd_i.feature == SUB_FREEZE |-> ##2 s_ok ##[0:1] frozen_o)
        else $error("freeze did not lock");
    a_set_twice: assert property (
        take && !frozen_o && !sec_locked_i && modified_o && cmd_i.feature == SUB_SET
        |-> ##2 s_abort(RSN_MODIFIED) ##0 result_o.word == W_REV)
        else $error("second set not refused");
    a_restore_full: assert property (
        take && !frozen_o && !sec_locked_i && !hpa_set_i && cmd_i.feature == SUB_RESTORE
        |-> ##2 s_ok ##[0:1] (eff_cap_o == full_cap_i && !modified_o))
        else $error("restore left a reduction");
    a_done_pulse: assert property (
        done_o |=> !done_o)
        else $error("done longer than one cycle");
    a_frozen_keep: assert property (disable iff (power_down_i)
        frozen_o |=> frozen_o)
        else $error("freeze lost without power-down");
    a_pd_clear: assert property (disable iff (rst_i)
        power_down_i |=> !frozen_o && !modified_o)
        else $error("power-down did not clear state");
    a_din_hold: assert property (
        din_valid_o && !din_ready_i |=> din_valid_o && $stable(din_word_o))
        else $error("data-in word dropped before taken");
    a_unmod_full: assert property (
        !modified_o |-> eff_cap_o == full_cap_i)
        else $error("reduction present without a set");
endmodule

bind config_overlay_cmd_handler dco_handler_asserts i_chk (
    .clock_i, .rst_i, .power_down_i, .cmd_valid_i, .cmd_i, .full_cap_i, .hpa_set_i,
    .sec_locked_i, .din_ready_i, .din_valid_o, .din_word_o, .busy_o, .done_o, .result_o,
    .eff_cap_o, .frozen_o, .modified_o);

`default_nettype wire

// ### test/config_overlay_cmd_handler_tb.sv
`timescale 1ns/1ns
`default_nettype none

module config_overlay_cmd_handler_tb
    import dco_pkg::*;
;
    localparam cap_words_t  FULL   = {16'h8005, 16'h803F, 16'h1BBF, 16'h0015, 16'h2000};
    localparam logic [63:0] NATIVE = 64'h0000_0000_1234_5678;

    logic        clock_i, rst_i, power_down_i, cmd_valid_i, stall, seen;
    logic        hpa_set_i, sec_enabled_i, sec_locked_i, din_ready_i, dout_valid_i;
    logic        din_valid_o, dout_ready_o, busy_o, done_o, frozen_o, modified_o;
    logic [15:0] din_word_o, dout_word_i;
    logic [63:0] native_lba_i, eff_lba_o;
    cmd_t        cmd_i;
    cap_words_t  full_cap_i, eff_cap_o;
    tf_result_t  result_o;
    logic [7:0]  bad [4] = '{8'h00, 8'hBF, 8'hC4, 8'hFF};
    int          mismatches = 0;
    int          n_checks = 0;

    config_overlay_cmd_handler i_dut (
        .clock_i, .rst_i, .power_down_i, .cmd_valid_i, .cmd_i, .full_cap_i, .native_lba_i,
        .hpa_set_i, .sec_enabled_i, .sec_locked_i, .din_ready_i, .din_valid_o, .din_word_o,
        .dout_valid_i, .dout_word_i, .dout_ready_o, .busy_o, .done_o, .result_o, .eff_cap_o,
        .eff_lba_o, .frozen_o, .modified_o);
    dco_host_model i_host (
        .clock_i, .stall_i(stall), .din_valid_i(din_valid_o), .din_word_i(din_word_o),
        .din_ready_o(din_ready_i), .dout_valid_o(dout_valid_i), .dout_word_o(dout_word_i),
        .dout_ready_i(dout_ready_o));

    initial
    begin
        clock_i = 1'b0;
        forever #10 clock_i = ~clock_i;
    end

    // Whole run is near 6.5k cycles; the limit leaves ample margin
    initial
    begin
        #800000;
        mismatches++;
        finish_test();
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic check(input string nm, input logic [79:0] got, input logic [79:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("FAIL %s expected %0h seen %0h", nm, exp, got);
        end
    endtask

    function automatic tf_result_t res(input logic [7:0] r, w, lo);
        return {r != RSN_NONE, r, w, 8'h00, lo};
    endfunction

    // Idle cycle first so the command never lands in a done cycle
    task automatic run(input logic [7:0] cmd, input logic [7:0] feat);
        @(negedge clock_i);
        i_host.tx_n = 0;
        i_host.rx_n = 0;
        cmd_i = {cmd, feat};
        cmd_valid_i = 1'b1;
        @(negedge clock_i);
        cmd_valid_i = 1'b0;
        seen = 1'b0;
        for (int k = 0; k < 1500 && !seen; k++)
        begin
            @(negedge clock_i);
            seen = (done_o === 1'b1);
        end
    endtask

    task automatic expect_res(input logic [7:0] feat, input tf_result_t exp);
        run(CMD_OVERLAY, feat);
        check("done", seen, 1'b1);
        check("busy", busy_o, 1'b0);
        check("result", result_o, exp);
    endtask

    function automatic logic [15:0] exp_word(input int i);
        case (i)
            0: return REV_VALUE;
            1: return FULL.mwdma & MASK_MWDMA;
            2: return FULL.udma & MASK_UDMA;
            3: return NATIVE[15:0];
            4: return NATIVE[31:16];
            5: return NATIVE[47:32];
            6: return NATIVE[63:48];
            7: return FULL.feat & MASK_FEAT;
            8: return FULL.sata & MASK_SATA;
            21: return FULL.wunc & MASK_WUNC;
            default: return 16'h0000;
        endcase
    endfunction

    task automatic identify_check(input logic slow);
        logic [7:0]  s;
        logic [15:0] w;
        stall = slow;
        expect_res(SUB_IDENTIFY, res(RSN_NONE, 8'h00, 8'h00));
        check("words", i_host.rx_n, 256);
        s = SIGNATURE;
        for (int i = 0; i < 255; i++)
        begin
            w = exp_word(i);
            s = s + w[7:0] + w[15:8];
            check("word", i_host.rx_mem[i], w);
        end
        check("integrity", i_host.rx_mem[255], {8'h00 - s, SIGNATURE});
    endtask

    task automatic do_set(input logic [15:0] mw, ud, ft, sa, input tf_result_t exp);
        for (int i = 0; i < 256; i++)
            i_host.tx_mem[i] = 16'h0000;
        i_host.tx_mem[1] = mw;
        i_host.tx_mem[2] = ud;
        i_host.tx_mem[3] = 16'h1000;
        i_host.tx_mem[7] = ft;
        i_host.tx_mem[8] = sa;
        stall = 1'b1;
        expect_res(SUB_SET, exp);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        {rst_i, power_down_i} = 2'b11;
        {cmd_valid_i, stall, hpa_set_i, sec_enabled_i, sec_locked_i} = '0;
        cmd_i = '0;
        full_cap_i = FULL;
        native_lba_i = NATIVE;
        repeat (8) @(negedge clock_i);
        {rst_i, power_down_i} = 2'b00;

        run(8'hB0, SUB_IDENTIFY);
        check("ignored", seen, 1'b0);
        foreach (bad[k])
            expect_res(bad[k], res(RSN_BAD_SUB, 8'h00, 8'h00));
        $display("test decode done");

        identify_check(1'b1);
        identify_check(1'b0);
        $display("test identify done");

        do_set(16'h0001, 16'h00C3, FULL.feat, 16'h0001, res(RSN_NONE, 8'h00, 8'h00));
        check("eff", eff_cap_o, {16'h0001, 16'h0003, 16'h1BBF, 16'h0001, 16'h0000});
        check("lba", eff_lba_o, 64'h0000_0000_0000_1000);
        check("modified", modified_o, 1'b1);
        identify_check(1'b0);
        do_set(FULL.mwdma, FULL.udma, FULL.feat, FULL.sata,
               res(RSN_MODIFIED, 8'h00, 8'h00));
        $display("test set done");

        hpa_set_i = 1'b1;
        expect_res(SUB_RESTORE, res(RSN_PROTECTED, 8'h03, 8'h00));
        {hpa_set_i, sec_locked_i} = 2'b01;
        expect_res(SUB_RESTORE, res(RSN_SEC_LOCKED, 8'h00, 8'h00));
        sec_locked_i = 1'b0;
        expect_res(SUB_RESTORE, res(RSN_NONE, 8'h00, 8'h00));
        check("eff", eff_cap_o, FULL);
        check("lba", eff_lba_o, NATIVE);
        sec_enabled_i = 1'b1;
        do_set(FULL.mwdma, FULL.udma, FULL.feat & ~16'h0008, FULL.sata,
               res(RSN_DISABLE, 8'h07, 8'h08));
        sec_enabled_i = 1'b0;
        hpa_set_i = 1'b1;
        do_set(FULL.mwdma, FULL.udma, FULL.feat, FULL.sata,
               res(RSN_PROTECTED, 8'h03, 8'h00));
        hpa_set_i = 1'b0;
        $display("test restore done");

        expect_res(SUB_FREEZE, res(RSN_NONE, 8'h00, 8'h00));
        for (int f = 8'hC0; f <= 8'hC3; f++)
            expect_res(f[7:0], res(RSN_FROZEN, 8'h00, 8'h00));
        rst_i = 1'b1;
        @(negedge clock_i);
        rst_i = 1'b0;
        check("frozen", frozen_o, 1'b1);
        expect_res(SUB_IDENTIFY, res(RSN_FROZEN, 8'h00, 8'h00));
        power_down_i = 1'b1;
        @(negedge clock_i);
        power_down_i = 1'b0;
        check("frozen", frozen_o, 1'b0);
        identify_check(1'b0);
        $display("test freeze done");
        finish_test();
    end
endmodule

`default_nettype wire
